// ===== src/pbr_defs.vh
// Constants for the push-button reset and fault response block
`ifndef PBR_DEFS_VH
`define PBR_DEFS_VH

`define PBR_CLK_MHZ        250
`define PBR_NOTIFY_US      128
`define PBR_NOTIFY_CYC     (`PBR_NOTIFY_US * `PBR_CLK_MHZ)
`define PBR_TICK_US        1000
`define PBR_TICK_CYC       (`PBR_TICK_US * `PBR_CLK_MHZ)
`define PBR_RESET_MS       400
`define PBR_CNT_W          20
`define PBR_MS_W           16

`define PBR_ADDR_W         4
`define PBR_REG_STATUS     4'h0
`define PBR_REG_PBCTL      4'h1
`define PBR_REG_WAKE_MS    4'h2
`define PBR_REG_RST_MS     4'h3
`define PBR_REG_FAULTS     4'h4
`define PBR_REG_CHARGE     4'h5

`define PBR_PBCTL_RST      8'h00
`define PBR_WAKE_FLAG_ONE_MS_RST   16'h01f4
`define PBR_WAKE_FLAG_TWO_MS_RST   16'h07d0
`define PBR_RSTP_MS_RST    16'h2710

`define PBR_CODE_READY     2'h0
`define PBR_CODE_CHG       2'h1
`define PBR_CODE_DONE      2'h2
`define PBR_CODE_FAULT     2'h3

`define PBR_ZONE_NORMAL    3'h0
`define PBR_ZONE_COLD      3'h1
`define PBR_ZONE_COOL      3'h2
`define PBR_ZONE_WARM      3'h3
`define PBR_ZONE_HOT       3'h4

`define PBR_WARM_DROP_MV   8'h8c

`endif

// ===== src/pbr_sync.v
// Two-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module pbr_sync #(
	parameter W = 1
) (
	ref_clk,
	rst_n,
	d_in,
	q_out
);
	input  wire         ref_clk;
	input  wire         rst_n;
	input  wire [W-1:0] d_in;
	output wire [W-1:0] q_out;

	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end else begin
			meta_r <= d_in;
			sync_r <= meta_r;
		end
	end

	assign q_out = sync_r;
endmodule

// ===== src/pbr_pulse.v
// Retriggerable fixed-length pulse generator
`timescale 1ns/1ps
module pbr_pulse #(
	parameter CW  = 20,
	parameter LEN = 32000
) (
	ref_clk,
	rst_n,
	trig,
	pulse_out
);
	input  wire ref_clk;
	input  wire rst_n;
	input  wire trig;
	output wire pulse_out;

	localparam [CW-1:0] LEN_C = LEN;
	reg [CW-1:0] cnt_r;

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= {CW{1'b0}};
		end else if (trig) begin
			cnt_r <= LEN_C;
		end else if (cnt_r != {CW{1'b0}}) begin
			cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
		end
	end

	assign pulse_out = (cnt_r != {CW{1'b0}});
endmodule

// ===== src/pbr_top.v
// Push-button wake/restart control and fault response sequencing
`timescale 1ns/1ps
`include "pbr_defs.vh"
module pbr_top #(
	parameter NOTIFY_CYC = `PBR_NOTIFY_CYC,
	parameter TICK_CYC   = `PBR_TICK_CYC,
	parameter RESET_MS   = `PBR_RESET_MS
) (
	ref_clk,
	rst_n,
	push_button_n,
	cell_supply_present,
	input_supply_valid,
	input_in_restart_window,
	charge_enable,
	input_overvolt,
	input_undervolt,
	input_current_limit_event,
	cell_undervolt,
	safety_timer_expired,
	input_droop_loop,
	thermistor_zone,
	charge_complete,
	cell_below_recharge,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	notify_out,
	restart_out_n,
	power_good_out,
	charger_on,
	precharge_on,
	input_current_reduced,
	charge_current_half,
	cell_regulation_drop_mv,
	thermistor_monitor_on,
	main_output_rail_on,
	rails_from_cell,
	ship_mode_req,
	hiz_mode_req,
	recharge_watch
);
	input  wire                   ref_clk;
	input  wire                   rst_n;
	input  wire                   push_button_n;
	input  wire                   cell_supply_present;
	input  wire                   input_supply_valid;
	input  wire                   input_in_restart_window;
	input  wire                   charge_enable;
	input  wire                   input_overvolt;
	input  wire                   input_undervolt;
	input  wire                   input_current_limit_event;
	input  wire                   cell_undervolt;
	input  wire                   safety_timer_expired;
	input  wire                   input_droop_loop;
	input  wire [2:0]             thermistor_zone;
	input  wire                   charge_complete;
	input  wire                   cell_below_recharge;
	input  wire [`PBR_ADDR_W-1:0] reg_addr;
	input  wire [7:0]             reg_wdata;
	input  wire                   reg_wr;
	input  wire                   reg_rd;
	output reg  [7:0]             reg_rdata;
	output wire                   notify_out;
	output wire                   restart_out_n;
	output reg                    power_good_out;
	output reg                    charger_on;
	output reg                    precharge_on;
	output reg                    input_current_reduced;
	output reg                    charge_current_half;
	output reg  [7:0]             cell_regulation_drop_mv;
	output reg                    thermistor_monitor_on;
	output reg                    main_output_rail_on;
	output reg                    rails_from_cell;
	output reg                    ship_mode_req;
	output reg                    hiz_mode_req;
	output reg                    recharge_watch;

	// ----------------------------------------
	// Reset release and input synchronisers
	// ----------------------------------------
	reg  [1:0] rst_sync_r;
	wire       rst_n_i;

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n_i = rst_sync_r[1];

	wire [17:0] raw_in;
	wire [17:0] syn_in;
	assign raw_in = {~push_button_n, cell_supply_present, input_supply_valid,
		input_in_restart_window, charge_enable, input_overvolt, input_undervolt,
		input_current_limit_event, cell_undervolt, safety_timer_expired,
		input_droop_loop, thermistor_zone, charge_complete, cell_below_recharge,
		2'b00};

	pbr_sync #(.W(18)) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n_i),
		.d_in    (raw_in),
		.q_out   (syn_in)
	);

	wire       btn_low   = syn_in[17];
	wire       cell_ok   = syn_in[16];
	wire       vin_ok    = syn_in[15];
	wire       vin_win   = syn_in[14];
	wire       chg_en    = syn_in[13];
	wire       ovp       = syn_in[12];
	wire       uvp       = syn_in[11];
	wire       ilim      = syn_in[10];
	wire       cuv       = syn_in[9];
	wire       tmr_exp   = syn_in[8];
	wire       droop     = syn_in[7];
	wire [2:0] zone      = syn_in[6:4];
	wire       done      = syn_in[3];
	wire       below_rch = syn_in[2];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0]            pbctl_r;
	reg [`PBR_MS_W-1:0]  wake_flag_one_ms_r;
	reg [`PBR_MS_W-1:0]  wake_flag_two_ms_r;
	reg [`PBR_MS_W-1:0]  rstp_ms_r;
	reg                  wake_flag_one_flag_r;
	reg                  wake_flag_two_flag_r;
	reg                  restart_flag_r;
	reg                  timer_flag_r;
	reg                  ovp_flag_r;
	reg                  uvp_flag_r;
	reg                  cuv_flag_r;
	reg                  droop_flag_r;
	reg [1:0]            code_r;
	reg [2:0]            zone_r;

	wire restart_recovery_sel    = pbctl_r[0];
	wire restart_needs_input_sel = pbctl_r[1];
	wire wake_en_one             = pbctl_r[2];
	wire wake_en_two             = pbctl_r[3];
	wire restart_en              = pbctl_r[4];
	wire rd_pbctl                = reg_rd && (reg_addr == `PBR_REG_PBCTL);

	// ----------------------------------------
	// Button timing
	// ----------------------------------------
	localparam [`PBR_CNT_W-1:0] TICK_C = TICK_CYC - 1;
	reg [`PBR_CNT_W-1:0] tick_cnt_r;
	reg [`PBR_MS_W-1:0]  press_ms_r;
	reg                  armed_r;
	reg                  wake_flag_one_done_r;
	reg                  wake_flag_two_done_r;
	reg                  rst_done_r;
	wire                 tick = (tick_cnt_r == {`PBR_CNT_W{1'b0}});
	wire btn_ok = cell_ok || (vin_ok && chg_en);
	wire pressed = btn_low && btn_ok;

	always @(posedge ref_clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt_r <= {`PBR_CNT_W{1'b0}};
			press_ms_r <= {`PBR_MS_W{1'b0}};
		end else if (!pressed) begin
			tick_cnt_r <= TICK_C;
			press_ms_r <= {`PBR_MS_W{1'b0}};
		end else if (tick) begin
			tick_cnt_r <= TICK_C;
			if (press_ms_r != {`PBR_MS_W{1'b1}})
				press_ms_r <= press_ms_r + {{(`PBR_MS_W-1){1'b0}}, 1'b1};
		end else begin
			tick_cnt_r <= tick_cnt_r - {{(`PBR_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	wire hit_w1  = pressed && wake_en_one && !wake_flag_one_done_r && (press_ms_r >= wake_flag_one_ms_r);
	wire hit_w2  = pressed && wake_en_two && !wake_flag_two_done_r && (press_ms_r >= wake_flag_two_ms_r);
	wire in_ok   = !restart_needs_input_sel || vin_win;
	wire hit_rst = pressed && restart_en && armed_r && !rst_done_r && in_ok
		&& (press_ms_r >= rstp_ms_r);
	wire rearm   = pressed && (press_ms_r >= wake_flag_one_ms_r);

	always @(posedge ref_clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_flag_one_done_r <= 1'b0;
			wake_flag_two_done_r <= 1'b0;
			rst_done_r   <= 1'b0;
			armed_r      <= 1'b1;
		end else begin
			if (!pressed) begin
				wake_flag_one_done_r <= 1'b0;
				wake_flag_two_done_r <= 1'b0;
				rst_done_r   <= 1'b0;
			end else begin
				if (hit_w1)
					wake_flag_one_done_r <= 1'b1;
				if (hit_w2)
					wake_flag_two_done_r <= 1'b1;
				if (hit_rst)
					rst_done_r <= 1'b1;
			end
			if (hit_rst)
				armed_r <= 1'b0;
			else if (rst_done_r == 1'b0 && rearm && !armed_r && !hit_rst)
				armed_r <= !rst_done_r;
		end
	end

	// ----------------------------------------
	// Restart output pulse
	// ----------------------------------------
	// Own time base, so the pulse also ends after an early release
	reg [`PBR_CNT_W-1:0] rout_cyc_r;
	reg [`PBR_MS_W-1:0]  rout_ms_r;
	reg                  rout_r;
	reg                  rout_vin_r;
	always @(posedge ref_clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rout_cyc_r <= {`PBR_CNT_W{1'b0}};
			rout_ms_r  <= {`PBR_MS_W{1'b0}};
			rout_r     <= 1'b0;
			rout_vin_r <= 1'b0;
		end else if (hit_rst && !rout_r) begin
			rout_r     <= 1'b1;
			rout_cyc_r <= TICK_C;
			rout_ms_r  <= RESET_MS[`PBR_MS_W-1:0];
			rout_vin_r <= vin_ok;
		end else if (rout_r && rout_cyc_r != {`PBR_CNT_W{1'b0}}) begin
			rout_cyc_r <= rout_cyc_r - {{(`PBR_CNT_W-1){1'b0}}, 1'b1};
		end else if (rout_r) begin
			rout_cyc_r <= TICK_C;
			if (rout_ms_r == {{(`PBR_MS_W-1){1'b0}}, 1'b1})
				rout_r <= 1'b0;
			rout_ms_r <= rout_ms_r - {{(`PBR_MS_W-1){1'b0}}, 1'b1};
		end
	end
	assign restart_out_n = ~rout_r;

	// Recovery after the restart pulse ends
	reg rout_d_r;
	wire rout_end = rout_d_r && !rout_r;
	always @(posedge ref_clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rout_d_r            <= 1'b0;
			ship_mode_req       <= 1'b0;
			hiz_mode_req        <= 1'b0;
			main_output_rail_on <= 1'b1;
		end else begin
			rout_d_r <= rout_r;
			if (rout_end && !rout_vin_r) begin
				ship_mode_req <= !restart_recovery_sel;
				hiz_mode_req  <= restart_recovery_sel;
				if (restart_recovery_sel)
					main_output_rail_on <= 1'b1;
			end else if (rout_end) begin
				ship_mode_req       <= 1'b0;
				hiz_mode_req        <= 1'b0;
				main_output_rail_on <= 1'b1;
			end else if (vin_ok) begin
				ship_mode_req <= 1'b0;
				hiz_mode_req  <= 1'b0;
			end
			if (reg_wr && reg_addr == `PBR_REG_STATUS)
				main_output_rail_on <= reg_wdata[0];
		end
	end

	// ----------------------------------------
	// Fault response and charge code
	// ----------------------------------------
	wire vin_bad = ovp || uvp;
	wire zone_ch = zone != zone_r;
	reg  [7:0] ev_d_r;
	wire [7:0] ev_now = {ovp, uvp, ilim, cuv, tmr_exp, droop, done, zone_ch};
	wire       fault_notify = |(ev_now & ~ev_d_r) || zone_ch;

	always @(posedge ref_clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ev_d_r                  <= 8'h00;
			zone_r                  <= `PBR_ZONE_NORMAL;
			code_r                  <= `PBR_CODE_READY;
			power_good_out          <= 1'b0;
			charger_on              <= 1'b0;
			precharge_on            <= 1'b0;
			input_current_reduced   <= 1'b0;
			charge_current_half     <= 1'b0;
			cell_regulation_drop_mv <= 8'h00;
			thermistor_monitor_on   <= 1'b0;
			rails_from_cell         <= 1'b0;
			recharge_watch          <= 1'b0;
		end else begin
			ev_d_r                  <= {ev_now[7:1], 1'b0};
			zone_r                  <= zone;
			power_good_out          <= vin_ok && !vin_bad;
			rails_from_cell         <= vin_bad || !vin_ok;
			thermistor_monitor_on   <= vin_ok && !vin_bad && !tmr_exp;
			input_current_reduced   <= ilim || droop;
			charge_current_half     <= (zone == `PBR_ZONE_COOL);
			cell_regulation_drop_mv <= (zone == `PBR_ZONE_WARM) ? `PBR_WARM_DROP_MV : 8'h00;
			precharge_on            <= cuv && vin_ok && !vin_bad;
			recharge_watch          <= done;
			charger_on              <= vin_ok && !vin_bad && chg_en && !tmr_exp
				&& (!done || below_rch)
				&& zone != `PBR_ZONE_COLD && zone != `PBR_ZONE_HOT;
			if (vin_bad || cuv || tmr_exp || droop || zone != `PBR_ZONE_NORMAL)
				code_r <= `PBR_CODE_FAULT;
			else if (done)
				code_r <= `PBR_CODE_DONE;
			else if (vin_ok && chg_en)
				code_r <= `PBR_CODE_CHG;
			else
				code_r <= `PBR_CODE_READY;
		end
	end

	// ----------------------------------------
	// Flags and register writes
	// ----------------------------------------
	always @(posedge ref_clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pbctl_r        <= `PBR_PBCTL_RST;
			wake_flag_one_ms_r     <= `PBR_WAKE_FLAG_ONE_MS_RST;
			wake_flag_two_ms_r     <= `PBR_WAKE_FLAG_TWO_MS_RST;
			rstp_ms_r      <= `PBR_RSTP_MS_RST;
			wake_flag_one_flag_r   <= 1'b0;
			wake_flag_two_flag_r   <= 1'b0;
			restart_flag_r <= 1'b0;
			timer_flag_r   <= 1'b0;
			ovp_flag_r     <= 1'b0;
			uvp_flag_r     <= 1'b0;
			cuv_flag_r     <= 1'b0;
			droop_flag_r   <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `PBR_REG_PBCTL)
				pbctl_r <= reg_wdata;
			else if (reg_wr && reg_addr == `PBR_REG_WAKE_MS)
				wake_flag_one_ms_r <= {8'h00, reg_wdata};
			else if (reg_wr && reg_addr == `PBR_REG_RST_MS)
				rstp_ms_r <= {reg_wdata, 8'h00};
			if (hit_w1 || (rd_pbctl == 1'b0 && wake_flag_one_flag_r))
				wake_flag_one_flag_r <= 1'b1;
			else if (rd_pbctl)
				wake_flag_one_flag_r <= 1'b0;
			if (hit_w2 || (!rd_pbctl && wake_flag_two_flag_r))
				wake_flag_two_flag_r <= 1'b1;
			else if (rd_pbctl)
				wake_flag_two_flag_r <= 1'b0;
			if (hit_rst)
				restart_flag_r <= 1'b1;
			else if (rd_pbctl)
				restart_flag_r <= 1'b0;
			ovp_flag_r   <= ovp;
			uvp_flag_r   <= uvp;
			cuv_flag_r   <= cuv;
			droop_flag_r <= droop;
			if (tmr_exp)
				timer_flag_r <= 1'b1;
			else if (!chg_en)
				timer_flag_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Host notification pulse
	// ----------------------------------------
	pbr_pulse #(.CW(`PBR_CNT_W), .LEN(NOTIFY_CYC)) u_notify (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n_i),
		.trig      (hit_w1 || hit_w2 || hit_rst || fault_notify),
		.pulse_out (notify_out)
	);

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always @(posedge ref_clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr == `PBR_REG_STATUS) begin
			reg_rdata <= {code_r, 1'b0, restart_flag_r, timer_flag_r, droop_flag_r,
				!chg_en, main_output_rail_on};
		end else if (reg_addr == `PBR_REG_PBCTL) begin
			reg_rdata <= {wake_flag_one_flag_r, wake_flag_two_flag_r, restart_flag_r, pbctl_r[4:0]};
		end else if (reg_addr == `PBR_REG_WAKE_MS) begin
			reg_rdata <= wake_flag_one_ms_r[7:0];
		end else if (reg_addr == `PBR_REG_RST_MS) begin
			reg_rdata <= rstp_ms_r[15:8];
		end else if (reg_addr == `PBR_REG_FAULTS) begin
			reg_rdata <= {4'h0, ovp_flag_r, uvp_flag_r, cuv_flag_r, 1'b0};
		end else if (reg_addr == `PBR_REG_CHARGE) begin
			reg_rdata <= {3'h0, zone_r, code_r};
		end else begin
			reg_rdata <= 8'hff;
		end
	end
endmodule

// ===== testbench/pbr_top_sva.sv
// Assertion checker for the push-button and fault response block
`timescale 1ns/1ps
module pbr_top_sva #(
	parameter NOTIFY_CYC = 8,
	parameter TICK_CYC   = 10,
	parameter RESET_MS   = 2
) (
	input wire       ref_clk,
	input wire       rst_n,
	input wire       notify_out,
	input wire       restart_out_n,
	input wire       power_good_out,
	input wire       charger_on,
	input wire       thermistor_monitor_on,
	input wire       rails_from_cell,
	input wire       charge_current_half,
	input wire [7:0] cell_regulation_drop_mv,
	input wire       input_overvolt,
	input wire       input_undervolt,
	input wire       cell_undervolt,
	input wire       input_supply_valid,
	input wire       safety_timer_expired,
	input wire [2:0] thermistor_zone,
	input wire       charge_complete,
	input wire       cell_below_recharge
);
	// ----------------------------------------
	// Pulse length counters and settle guard
	// ----------------------------------------
	reg [3:0]  live_r;
	reg [15:0] hi_r;
	reg [15:0] lo_r;
	wire       live = (live_r == 4'hf);
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			live_r <= 4'h0;
			hi_r <= 16'h0;
			lo_r <= 16'h0;
		end else begin
			if (!live)
				live_r <= live_r + 4'h1;
			hi_r <= notify_out ? hi_r + 16'h1 : 16'h0;
			lo_r <= restart_out_n ? 16'h0 : lo_r + 16'h1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_in_bad;
		live && (input_overvolt || input_undervolt);
	endsequence
	sequence s_hot_cold;
		live && (thermistor_zone == 3'h1 || thermistor_zone == 3'h4);
	endsequence
	sequence s_done;
		live && charge_complete && !cell_below_recharge;
	endsequence
	AST_NOTIFY_LEN: assert property ($fell(notify_out) |-> hi_r >= NOTIFY_CYC)
		else $error("notify pulse too short");
	AST_RESTART_LEN: assert property ($rose(restart_out_n) |->
		lo_r >= (RESET_MS - 1) * TICK_CYC && lo_r <= (RESET_MS + 1) * TICK_CYC)
		else $error("restart pulse length wrong");
	AST_RESTART_NOTIFY: assert property ($fell(restart_out_n) |-> ##[0:3] notify_out)
		else $error("restart without notify");
	AST_INPUT_FAULT: assert property (s_in_bad [*5] |-> !power_good_out && !charger_on
		&& !thermistor_monitor_on && rails_from_cell)
		else $error("input fault response wrong");
	AST_CELL_UV: assert property ((live && cell_undervolt && !input_supply_valid) [*5]
		|-> !thermistor_monitor_on)
		else $error("thermistor on without input");
	AST_TIMER: assert property ((live && safety_timer_expired) [*5]
		|-> !charger_on && !thermistor_monitor_on)
		else $error("timer fault response wrong");
	AST_HOT_COLD: assert property (s_hot_cold [*5] |-> !charger_on)
		else $error("charging in cold or hot zone");
	AST_COOL: assert property ((live && thermistor_zone == 3'h2) [*5] |-> charge_current_half)
		else $error("cool zone current not halved");
	AST_WARM: assert property ((live && thermistor_zone == 3'h3) [*5]
		|-> cell_regulation_drop_mv == 8'h8c)
		else $error("warm zone drop wrong");
	AST_DONE: assert property (s_done [*5] |-> !charger_on)
		else $error("charging after done");
endmodule
bind pbr_top pbr_top_sva #(.NOTIFY_CYC(NOTIFY_CYC), .TICK_CYC(TICK_CYC), .RESET_MS(RESET_MS))
	pbr_top_sva_inst (.ref_clk(ref_clk), .rst_n(rst_n), .notify_out(notify_out),
	.restart_out_n(restart_out_n), .power_good_out(power_good_out), .charger_on(charger_on),
	.thermistor_monitor_on(thermistor_monitor_on), .rails_from_cell(rails_from_cell),
	.charge_current_half(charge_current_half),
	.cell_regulation_drop_mv(cell_regulation_drop_mv), .input_overvolt(input_overvolt),
	.input_undervolt(input_undervolt), .cell_undervolt(cell_undervolt),
	.input_supply_valid(input_supply_valid), .safety_timer_expired(safety_timer_expired),
	.thermistor_zone(thermistor_zone), .charge_complete(charge_complete),
	.cell_below_recharge(cell_below_recharge));

// ===== testbench/pbr_host_model.sv
// Host processor and push-button model for the reset block bench
`timescale 1ns/1ps
module pbr_host_model (
	input  wire ref_clk,
	input  wire notify_out,
	input  wire restart_out_n,
	output reg  push_button_n
);
	// ----------------------------------------
	// Edge counters and button driver
	// ----------------------------------------
	integer notify_cnt;
	integer restart_cnt;
	reg     notify_q;
	reg     restart_q;
	initial begin
		push_button_n = 1'b1;
		notify_cnt = 0;
		restart_cnt = 0;
		notify_q = 1'b0;
		restart_q = 1'b1;
	end
	always @(posedge ref_clk) begin
		notify_q <= notify_out;
		restart_q <= restart_out_n;
		if (notify_out && !notify_q)
			notify_cnt <= notify_cnt + 1;
		if (!restart_out_n && restart_q)
			restart_cnt <= restart_cnt + 1;
	end
	// Low for a count of cycles, then back to the pull-up level
	task press(input integer cyc);
		begin
			push_button_n <= 1'b0;
			repeat (cyc) @(posedge ref_clk);
			push_button_n <= 1'b1;
			repeat (50) @(posedge ref_clk);
		end
	endtask
endmodule

// ===== testbench/tb_pbr_top.sv
// Testbench for the push-button and fault response block
`timescale 1ns/1ps
module tb_pbr_top;
	// ----------------------------------------
	// Stimulus, tasks and checks
	// ----------------------------------------
	reg        ref_clk;
	reg        rst_n;
	wire       pb_n;
	reg        cell_p;
	reg        in_valid;
	reg        in_win;
	reg        chg_en;
	reg  [6:0] flt;
	reg        rchg_low;
	wire       f_ov, f_uv, f_ilim, f_cuv, f_tmr, f_droop, f_done;
	reg  [2:0] zone;
	reg  [3:0] reg_addr;
	reg  [7:0] reg_wdata;
	reg        reg_wr;
	reg        reg_rd;
	wire [7:0] reg_rdata;
	wire [7:0] drop_mv;
	wire       notify_out, restart_out_n, pg, chg_on, pre_on, in_red, half, therm_on;
	wire       rail_on, from_cell, ship_req, hiz_req, rchg_watch;
	integer    fail_count, n_checks, cyc_cnt, i, n0, r0;
	assign {f_done, f_droop, f_tmr, f_cuv, f_ilim, f_uv, f_ov} = flt;
	pbr_top #(.NOTIFY_CYC(8), .TICK_CYC(10), .RESET_MS(2)) pbr_top_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .push_button_n(pb_n), .cell_supply_present(cell_p),
		.input_supply_valid(in_valid), .input_in_restart_window(in_win),
		.charge_enable(chg_en), .input_overvolt(f_ov), .input_undervolt(f_uv),
		.input_current_limit_event(f_ilim), .cell_undervolt(f_cuv),
		.safety_timer_expired(f_tmr), .input_droop_loop(f_droop), .thermistor_zone(zone),
		.charge_complete(f_done), .cell_below_recharge(rchg_low), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.notify_out(notify_out), .restart_out_n(restart_out_n), .power_good_out(pg),
		.charger_on(chg_on), .precharge_on(pre_on), .input_current_reduced(in_red),
		.charge_current_half(half), .cell_regulation_drop_mv(drop_mv),
		.thermistor_monitor_on(therm_on), .main_output_rail_on(rail_on),
		.rails_from_cell(from_cell), .ship_mode_req(ship_req), .hiz_mode_req(hiz_req),
		.recharge_watch(rchg_watch));
	pbr_host_model pbr_host_model_inst (.ref_clk(ref_clk), .notify_out(notify_out),
		.restart_out_n(restart_out_n), .push_button_n(pb_n));
	always #2 ref_clk = ~ref_clk;
	task conclude;
		begin
			$display("checks %0d mismatches %0d", n_checks, fail_count);
			if (fail_count == 0 && n_checks > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	always @(posedge ref_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 60000) begin
			fail_count = fail_count + 1;
			conclude;
		end
	end
	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge ref_clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [7:0] m, input [7:0] exp);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge ref_clk);
			reg_rd <= 1'b0;
			#1 chk(reg_rdata & m, exp);
			@(posedge ref_clk);
		end
	endtask
	task do_rst(input [7:0] ctl);
		begin
			rst_n <= 1'b0;
			repeat (10) @(posedge ref_clk);
			rst_n <= 1'b1;
			repeat (6) @(posedge ref_clk);
			rd(4'h1, 8'hff, 8'h00);
			rd(4'hf, 8'hff, 8'hff);
			wr(4'h2, 8'h02);
			wr(4'h3, 8'h01);
			wr(4'h1, ctl);
			repeat (10) @(posedge ref_clk);
		end
	endtask
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		{cell_p, in_valid, in_win, chg_en, reg_wr, reg_rd, rchg_low} = 7'h00;
		{flt, zone, reg_addr, reg_wdata} = 22'h0;
		{fail_count, n_checks, cyc_cnt} = 0;
		do_rst(8'h14);
		pbr_host_model_inst.press(3000);
		chk(pbr_host_model_inst.notify_cnt[7:0], 8'h00);
		chk(pbr_host_model_inst.restart_cnt[7:0], 8'h00);
		cell_p <= 1'b1;
		repeat (10) @(posedge ref_clk);
		pbr_host_model_inst.press(100);
		chk(pbr_host_model_inst.notify_cnt[7:0], 8'h01);
		rd(4'h1, 8'he0, 8'h80);
		rd(4'h1, 8'he0, 8'h00);
		pbr_host_model_inst.press(3000);
		chk(pbr_host_model_inst.restart_cnt[7:0], 8'h01);
		chk({7'h0, ship_req}, 8'h01);
		rd(4'h1, 8'h20, 8'h20);
		pbr_host_model_inst.press(3000);
		chk(pbr_host_model_inst.restart_cnt[7:0], 8'h02);
		do_rst(8'h15);
		wr(4'h0, 8'h00);
		rd(4'h0, 8'h01, 8'h00);
		pbr_host_model_inst.press(3000);
		chk({7'h0, hiz_req}, 8'h01);
		chk({7'h0, rail_on}, 8'h01);
		do_rst(8'h16);
		in_valid <= 1'b1;
		chg_en <= 1'b1;
		repeat (20) @(posedge ref_clk);
		r0 = pbr_host_model_inst.restart_cnt;
		pbr_host_model_inst.press(3000);
		chk(pbr_host_model_inst.restart_cnt - r0, 8'h00);
		in_win <= 1'b1;
		repeat (10) @(posedge ref_clk);
		pbr_host_model_inst.press(3000);
		chk(pbr_host_model_inst.restart_cnt - r0, 8'h01);
		chk({6'h0, ship_req, hiz_req}, 8'h00);
		for (i = 0; i < 11; i = i + 1) begin
			n0 = pbr_host_model_inst.notify_cnt;
			flt <= (i < 7) ? (7'h01 << i) : 7'h00;
			zone <= (i < 7) ? 3'h0 : i - 6;
			repeat (20) @(posedge ref_clk);
			chk({7'h0, pbr_host_model_inst.notify_cnt > n0}, 8'h01);
			rd(4'h5, 8'hff, {3'h0, zone, (i == 2) ? 2'h1 : (i == 6) ? 2'h2 : 2'h3});
			case (i)
				0: chk({6'h0, pg, from_cell}, 8'h01);
				1: chk({6'h0, pg, chg_on}, 8'h00);
				2: chk({7'h0, chg_on}, 8'h01);
				3: chk({7'h0, pre_on}, 8'h01);
				4: chk({7'h0, therm_on}, 8'h00);
				5: chk({6'h0, in_red, chg_on}, 8'h03);
				6: chk({6'h0, rchg_watch, chg_on}, 8'h02);
				7: chk({7'h0, chg_on}, 8'h00);
				8: chk({7'h0, half}, 8'h01);
				9: chk(drop_mv, 8'h8c);
				default: chk({7'h0, chg_on}, 8'h00);
			endcase
			flt <= 7'h00;
			zone <= 3'h0;
			chg_en <= 1'b0;
			repeat (10) @(posedge ref_clk);
			chg_en <= 1'b1;
			repeat (20) @(posedge ref_clk);
		end
		flt <= 7'h40;
		rchg_low <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk({6'h0, rchg_watch, chg_on}, 8'h03);
		flt <= 7'h08;
		rchg_low <= 1'b0;
		in_valid <= 1'b0;
		repeat (20) @(posedge ref_clk);
		chk({6'h0, pre_on, therm_on}, 8'h00);
		conclude;
	end
endmodule
